// File: design/host_buffer_memory_arbiter.sv
`timescale 1ns/100ps
`include "hbm_params.svh"
module host_buffer_memory_arbiter (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cpu_req,
    input wire logic cpu_we,
    input wire logic [15:0] cpu_addr,
    input wire logic [31:0] cpu_wdata,
    output logic cpu_ack_q,
    output logic cpu_err_q,
    output logic [31:0] cpu_rdata_q,
    output hbm_pkg::area_type cpu_area_q,
    output logic [4:0] cpu_index_q,
    input wire logic usb_req,
    input wire logic usb_we,
    input wire logic [12:0] usb_word_addr,
    input wire logic [63:0] usb_wdata,
    output logic usb_ack_q,
    output logic [63:0] usb_rdata_q,
    input wire logic usb_done,
    input wire logic [1:0] usb_done_area,
    input wire logic [4:0] usb_done_index,
    input wire logic [95:0] event_clear,
    input wire logic [95:0] event_any_mask,
    input wire logic [95:0] event_all_mask,
    output logic [95:0] event_flags_q,
    output logic irq_q
);
    localparam int BYTES_PER_CYCLE = 8;
    localparam int PEAK_MBPS = `HBM_CLK_MHZ * BYTES_PER_CYCLE;

    ram_port_if ram ();

    buffer_ram u_ram (
        .clk(clk),
        .rst_n(rst_n),
        .ram(ram)
    );

    // ==========================================================
    // Address decode
    logic [15:0] cpu_offset;
    logic cpu_bad;
    hbm_pkg::area_type cpu_area;
    logic [4:0] cpu_index;

    assign cpu_offset = cpu_addr - `HBM_RAM_BASE;

    always_comb begin
        cpu_index = 5'h00;
        // Register space belongs to another block
        if (cpu_addr < `HBM_RAM_BASE) begin
            cpu_area = hbm_pkg::AREA_PAYLOAD;
        end else if (cpu_addr <= `HBM_ISO_END) begin
            cpu_area = hbm_pkg::AREA_ISO;
            cpu_index = cpu_addr[9:5];
        end else if (cpu_addr <= `HBM_INT_END) begin
            cpu_area = hbm_pkg::AREA_INT;
            cpu_index = cpu_addr[9:5];
        end else if (cpu_addr <= `HBM_DESC_END) begin
            cpu_area = hbm_pkg::AREA_BULK;
            cpu_index = cpu_addr[9:5];
        end else begin
            cpu_area = hbm_pkg::AREA_PAYLOAD;
        end
    end

    // Misaligned or register-space accesses never reach the RAM
    assign cpu_bad = (cpu_addr < `HBM_RAM_BASE) ||
                     (cpu_addr[1:0] != 2'b00);

    // ==========================================================
    // Arbitration
    logic cpu_busy_q;
    logic usb_busy_q;
    hbm_pkg::requester_type last_q;
    logic cpu_want;
    logic usb_want;
    logic cpu_gnt;
    logic usb_gnt;
    logic cpu_take;

    assign cpu_want = cpu_req && !cpu_busy_q && !cpu_bad;
    assign usb_want = usb_req && !usb_busy_q;

    always_comb begin
        cpu_gnt = 1'b0;
        usb_gnt = 1'b0;
        if (cpu_want && usb_want) begin
            // Whoever was not granted last time wins now
            cpu_gnt = (last_q == hbm_pkg::REQ_USB);
            usb_gnt = (last_q == hbm_pkg::REQ_CPU);
        end else begin
            cpu_gnt = cpu_want;
            usb_gnt = usb_want;
        end
    end

    assign cpu_take = cpu_gnt || (cpu_req && !cpu_busy_q && cpu_bad);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            last_q <= hbm_pkg::REQ_USB;
        end else if (cpu_gnt) begin
            last_q <= hbm_pkg::REQ_CPU;
        end else if (usb_gnt) begin
            last_q <= hbm_pkg::REQ_USB;
        end
    end

    // Busy covers take (processor) or grant (engine) through ack so a held request is not retaken
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cpu_busy_q <= 1'b0;
        end else if (cpu_take) begin
            cpu_busy_q <= 1'b1;
        end else if (cpu_ack_q) begin
            cpu_busy_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            usb_busy_q <= 1'b0;
        end else if (usb_gnt) begin
            usb_busy_q <= 1'b1;
        end else if (usb_ack_q) begin
            usb_busy_q <= 1'b0;
        end
    end

    // ==========================================================
    // RAM port, one 64-bit row per cycle
    always_comb begin
        ram.en = cpu_gnt || usb_gnt;
        ram.we = usb_we;
        ram.addr = usb_word_addr;
        ram.be = 2'b11;
        ram.wdata = usb_wdata;
        if (cpu_gnt) begin
            ram.we = cpu_we;
            ram.addr = cpu_offset[15:3];
            // Lane enables keep the other double word intact
            ram.be = cpu_addr[2] ? 2'b10 : 2'b01;
            ram.wdata = {cpu_wdata, cpu_wdata};
        end
    end

    // ==========================================================
    // Answer pipeline
    logic cpu_v1_q;
    logic cpu_err1_q;
    logic cpu_lane1_q;
    hbm_pkg::area_type cpu_area1_q;
    logic [4:0] cpu_index1_q;
    logic usb_v1_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cpu_v1_q <= 1'b0;
            cpu_err1_q <= 1'b0;
            cpu_lane1_q <= 1'b0;
            cpu_area1_q <= hbm_pkg::AREA_PAYLOAD;
            cpu_index1_q <= 5'h00;
            usb_v1_q <= 1'b0;
        end else begin
            cpu_v1_q <= cpu_take;
            cpu_err1_q <= cpu_take && !cpu_gnt;
            cpu_lane1_q <= cpu_addr[2];
            cpu_area1_q <= cpu_area;
            cpu_index1_q <= cpu_index;
            usb_v1_q <= usb_gnt;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cpu_ack_q <= 1'b0;
            cpu_err_q <= 1'b0;
            cpu_rdata_q <= 32'h0000_0000;
            cpu_area_q <= hbm_pkg::AREA_PAYLOAD;
            cpu_index_q <= 5'h00;
        end else begin
            cpu_ack_q <= cpu_v1_q;
            if (cpu_v1_q) begin
                cpu_err_q <= cpu_err1_q;
                cpu_area_q <= cpu_area1_q;
                cpu_index_q <= cpu_index1_q;
                cpu_rdata_q <= cpu_err1_q ? 32'h0000_0000 :
                    (cpu_lane1_q ? ram.rdata[63:32] : ram.rdata[31:0]);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            usb_ack_q <= 1'b0;
            usb_rdata_q <= 64'h0000_0000_0000_0000;
        end else begin
            usb_ack_q <= usb_v1_q;
            if (usb_v1_q) begin
                usb_rdata_q <= ram.rdata;
            end
        end
    end

    // ==========================================================
    // Completion events
    logic [6:0] done_slot;
    assign done_slot = {usb_done_area, usb_done_index};

    genvar g;
    generate
        for (g = 0; g < `HBM_EVENT_BITS; g++) begin : evt
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    event_flags_q[g] <= 1'b0;
                end else if (usb_done && done_slot == 7'(g)) begin
                    event_flags_q[g] <= 1'b1;
                end else if (event_clear[g]) begin
                    event_flags_q[g] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= (|(event_flags_q & event_any_mask)) ||
                     ((|event_all_mask) &&
                      (&(event_flags_q | ~event_all_mask)));
        end
    end

    // ==========================================================
    // Checks
    a_bw_budget: assert property (@(posedge clk) disable iff (!rst_n)
        PEAK_MBPS >= `HBM_BW_MBPS)
        else $error("Peak bandwidth below budget");
    a_fair_turn: assert property (@(posedge clk) disable iff (!rst_n)
        cpu_want && usb_want && last_q == hbm_pkg::REQ_CPU
        |-> usb_gnt && !cpu_gnt)
        else $error("Engine not granted on its turn");
    a_ack_latency: assert property (@(posedge clk) disable iff (!rst_n)
        cpu_take |-> !cpu_ack_q ##1 !cpu_ack_q ##1 cpu_ack_q)
        else $error("Processor ack not two cycles after take");
    a_usb_latency: assert property (@(posedge clk) disable iff (!rst_n)
        usb_gnt |-> ##2 usb_ack_q)
        else $error("Engine ack not two cycles after grant");
    a_reg_refused: assert property (@(posedge clk) disable iff (!rst_n)
        cpu_take && cpu_addr < `HBM_RAM_BASE
        |-> !cpu_gnt ##2 cpu_ack_q && cpu_err_q)
        else $error("Register space access not refused");
    a_align_refused: assert property (@(posedge clk) disable iff (!rst_n)
        cpu_take && cpu_addr[1:0] != 2'b00 |-> ##2 cpu_err_q)
        else $error("Misaligned access not refused");
    a_word_map: assert property (@(posedge clk) disable iff (!rst_n)
        cpu_gnt |-> ram.addr <= `HBM_WORD_LAST &&
        {ram.addr, 3'b000} == cpu_addr - `HBM_RAM_BASE
            - {13'h0000, cpu_addr[2:0]})
        else $error("Word address not offset shifted by three");
    a_area_map: assert property (@(posedge clk) disable iff (!rst_n)
        cpu_take && !cpu_bad |-> ##2 cpu_ack_q &&
        ((cpu_area_q == hbm_pkg::AREA_PAYLOAD) ==
         ($past(cpu_addr, 2) >= `HBM_PAYLOAD_BASE)))
        else $error("Payload area decode wrong");
    a_event_sticky: assert property (@(posedge clk) disable iff (!rst_n)
        usb_done && usb_done_area != 2'b11
        |=> event_flags_q[$past(done_slot)])
        else $error("Completion event not captured");
    a_irq_any: assert property (@(posedge clk) disable iff (!rst_n)
        |(event_flags_q & event_any_mask) |=> irq_q)
        else $error("Unmasked event did not raise interrupt");
    c_both_req: cover property (@(posedge clk) cpu_want && usb_want);
    c_cpu_write: cover property (@(posedge clk) cpu_gnt && cpu_we);
    c_refused: cover property (@(posedge clk) cpu_ack_q && cpu_err_q);
    c_irq: cover property (@(posedge clk) $rose(irq_q));
endmodule

// File: design/hbm_params.svh
`ifndef HBM_PARAMS_SVH
`define HBM_PARAMS_SVH

// ==========================================================
// Address map, byte addresses seen by the processor
`define HBM_SPACE_KB 64
`define HBM_REG_KB 1
`define HBM_RAM_KB 63
`define HBM_PAYLOAD_KB 60
`define HBM_RAM_BASE 16'h0400
`define HBM_ISO_END 16'h07ff
`define HBM_INT_BASE 16'h0800
`define HBM_INT_END 16'h0bff
`define HBM_BULK_BASE 16'h0c00
`define HBM_DESC_END 16'h0fff
`define HBM_PAYLOAD_BASE 16'h1000
`define HBM_PAYLOAD_END 16'hffff

// ==========================================================
// Internal RAM shape
`define HBM_WORD_SHIFT 3
`define HBM_RAM_DEPTH 8192
`define HBM_WORD_LAST 13'h1fff
`define HBM_DESC_PER_AREA 32
`define HBM_DESC_DWORDS 8
`define HBM_EVENT_BITS 96

// ==========================================================
// Timing
`define HBM_CLK_MHZ 40
`define HBM_BW_MBPS 240
`define HBM_ACK_CYCLES 2

`endif

// File: design/hbm_pkg.sv
package hbm_pkg;
    // ==========================================================
    // Region of a processor access
    typedef enum logic [1:0] {
        AREA_PAYLOAD,
        AREA_ISO,
        AREA_INT,
        AREA_BULK
    } area_type;

    typedef enum logic {
        REQ_CPU,
        REQ_USB
    } requester_type;
endpackage

// File: design/ram_port_if.sv
`timescale 1ns/100ps
interface ram_port_if;
    logic en;
    logic we;
    logic [12:0] addr;
    logic [1:0] be;
    logic [63:0] wdata;
    logic [63:0] rdata;
    modport ctrl (output en, output we, output addr, output be,
                  output wdata, input rdata);
    modport mem (input en, input we, input addr, input be,
                 input wdata, output rdata);
endinterface

// File: design/buffer_ram.sv
`timescale 1ns/100ps
`include "hbm_params.svh"
module buffer_ram (
    input wire logic clk,
    input wire logic rst_n,
    ram_port_if.mem ram
);
    // ==========================================================
    // One 32-bit lane per double word of the 64-bit row
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : lane
            logic [31:0] mem_q [`HBM_RAM_DEPTH];
            logic [31:0] rd_q;
            always_ff @(posedge clk) begin
                if (ram.en && ram.we && ram.be[g]) begin
                    mem_q[ram.addr] <= ram.wdata[32*g +: 32];
                end
            end
            always_ff @(posedge clk) begin
                if (ram.en) begin
                    rd_q <= mem_q[ram.addr];
                end
            end
            assign ram.rdata[32*g +: 32] = rd_q;
        end
    endgenerate

    // ==========================================================
    // Checks
    a_lane_enable: assert property (@(posedge clk) disable iff (!rst_n)
        ram.en |-> ram.be != 2'b00)
        else $error("RAM access with no lane enabled");
endmodule

// File: verif/cpu_master.sv
`timescale 1ns/100ps
// ==========================================================
// Processor side master, one access outstanding
module cpu_master (
    input wire logic clk,
    input wire logic cpu_ack_q,
    input wire logic cpu_err_q,
    input wire logic [31:0] cpu_rdata_q,
    output logic cpu_req,
    output logic cpu_we,
    output logic [15:0] cpu_addr,
    output logic [31:0] cpu_wdata
);
    initial begin
        cpu_req = 1'b0;
        cpu_we = 1'b0;
        cpu_addr = 16'h0000;
        cpu_wdata = 32'h0;
    end
    // Processor writes pushed from here; whole rows come first from the engine side
    // Callers keep reserved bits zero and size payloads
    task automatic access(input logic we, input logic [15:0] a,
            input logic [31:0] d, output logic err,
            output logic [31:0] rd, output logic ok);
        int n;
        n = 0;
        @(negedge clk);
        cpu_req = 1'b1;
        cpu_we = we;
        cpu_addr = a;
        cpu_wdata = d;
        @(negedge clk);
        while (cpu_ack_q !== 1'b1 && n < 12) begin
            @(negedge clk);
            n++;
        end
        ok = (cpu_ack_q === 1'b1);
        err = cpu_err_q;
        rd = cpu_rdata_q;
        @(negedge clk);
        // Released lines flip so stale values cannot pass
        cpu_req = 1'b0;
        cpu_we = ~cpu_we;
        cpu_addr = ~cpu_addr;
        cpu_wdata = ~cpu_wdata;
    endtask
endmodule

// File: verif/host_buffer_memory_arbiter_tb.sv
`timescale 1ns/100ps
module host_buffer_memory_arbiter_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    wire logic cpu_req, cpu_we, cpu_ack_q, cpu_err_q;
    wire logic [15:0] cpu_addr;
    wire logic [31:0] cpu_wdata, cpu_rdata_q;
    hbm_pkg::area_type cpu_area_q;
    logic [4:0] cpu_index_q, usb_done_index = 5'h0;
    logic usb_req = 1'b0, usb_we = 1'b0, usb_ack_q, usb_done = 1'b0, irq_q;
    logic [12:0] usb_word_addr = 13'h0;
    logic [63:0] usb_wdata = 64'h0, usb_rdata_q, mem_m [int], r64, d64;
    logic [1:0] usb_done_area = 2'h0;
    logic [95:0] event_clear = '0, event_any_mask = '0;
    logic [95:0] event_all_mask = '0, event_flags_q, ev_m = '0;
    logic [15:0] seed = 16'h001c, adr [12];
    logic [31:0] r32, d32;
    logic ok, err, ok2;
    int fails = 0, tests_run = 0, w, b;
    cpu_master u_cpu_master (.clk(clk), .cpu_ack_q(cpu_ack_q),
        .cpu_err_q(cpu_err_q), .cpu_rdata_q(cpu_rdata_q),
        .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_addr(cpu_addr),
        .cpu_wdata(cpu_wdata));
    host_buffer_memory_arbiter u_host_buffer_memory_arbiter (.clk(clk),
        .rst_n(rst_n), .cpu_req(cpu_req), .cpu_we(cpu_we),
        .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_ack_q(cpu_ack_q),
        .cpu_err_q(cpu_err_q), .cpu_rdata_q(cpu_rdata_q),
        .cpu_area_q(cpu_area_q), .cpu_index_q(cpu_index_q),
        .usb_req(usb_req), .usb_we(usb_we), .usb_word_addr(usb_word_addr),
        .usb_wdata(usb_wdata), .usb_ack_q(usb_ack_q),
        .usb_rdata_q(usb_rdata_q), .usb_done(usb_done),
        .usb_done_area(usb_done_area), .usb_done_index(usb_done_index),
        .event_clear(event_clear), .event_any_mask(event_any_mask),
        .event_all_mask(event_all_mask), .event_flags_q(event_flags_q),
        .irq_q(irq_q));
    initial forever #12.5 clk = ~clk;
    function automatic logic [15:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed;
    endfunction
    task automatic chk(input logic [95:0] got, input logic [95:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t mismatch %h vs %h", $time, got, exp);
        end
    endtask
    task automatic usb_acc(input logic we, input logic [12:0] a,
            input logic [63:0] d, output logic [63:0] rd);
        int n;
        n = 0;
        @(negedge clk);
        usb_req = 1'b1;
        usb_we = we;
        usb_word_addr = a;
        usb_wdata = d;
        @(negedge clk);
        while (usb_ack_q !== 1'b1 && n < 12) begin
            @(negedge clk);
            n++;
        end
        chk(usb_ack_q, 1'b1);
        rd = usb_rdata_q;
        @(negedge clk);
        usb_req = 1'b0;
        usb_word_addr = ~a;
        usb_wdata = ~d;
    endtask
    task automatic pulse(input logic [1:0] ar, input logic [4:0] ix);
        @(negedge clk);
        usb_done = 1'b1;
        usb_done_area = ar;
        usb_done_index = ix;
        @(negedge clk);
        usb_done = 1'b0;
        event_clear = '0;
    endtask
    task automatic end_sim();
        $display("TB: fails=%0d tests_run=%0d", fails, tests_run);
        if (fails == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        fails++;
        end_sim();
    end
    initial begin
        adr = '{16'h0400, 16'h07fc, 16'h0800, 16'h0bfc, 16'h0c00,
            16'h0ffc, 16'h1000, 16'hfffc, 0, 0, 0, 0};
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        for (int i = 0; i < 12; i++) begin
            if (i > 7) adr[i] = (rnd() | 16'h1000) & 16'hfffc;
            w = (adr[i] - 16'h0400) >> 3;
            d64 = {rnd(), rnd(), rnd(), rnd()};
            d32 = {rnd(), rnd()};
            usb_acc(1'b1, 13'(w), d64, r64);
            mem_m[w] = d64;
            u_cpu_master.access(1'b1, adr[i], d32, err, r32, ok);
            b = adr[i][2] ? 32 : 0;
            mem_m[w][b +: 32] = d32;
            chk({ok, err}, 2'b10);
            chk(cpu_area_q, adr[i] < 16'h0800 ? 1 : adr[i] < 16'h0c00 ? 2 :
                adr[i] < 16'h1000 ? 3 : 0);
            chk(cpu_index_q, adr[i] < 16'h1000 ?
                (adr[i] - 16'h0400) % 16'h0400 / 32 : 0);
            fork
                u_cpu_master.access(1'b0, adr[i], 32'h0, err, r32, ok2);
                usb_acc(1'b0, 13'(w), 64'h0, r64);
            join
            chk({ok2, err}, 2'b10);
            chk(r32, mem_m[w][b +: 32]);
            chk(r64, mem_m[w]);
        end
        $display("TB: map and arbitration test done");
        // Refused: register space and misaligned
        foreach (adr[i]) if (i < 3) begin
            d32 = i == 0 ? 32'h0000_03f8 : i == 1 ? 32'h0000_1002 :
                32'h0000_0000;
            u_cpu_master.access(1'b1, d32[15:0], 32'hffff, err, r32, ok);
            chk({ok, err}, 2'b11);
            u_cpu_master.access(1'b0, d32[15:0], 32'h0, err, r32, ok);
            chk({ok, err, r32}, {2'b11, 32'h0});
        end
        usb_acc(1'b0, 13'h0180, 64'h0, r64);
        chk(r64, mem_m[13'h0180]);
        usb_acc(1'b0, 13'h1fff, 64'h0, r64);
        chk(r64, mem_m[13'h1fff]);
        $display("TB: refusal test done");
        for (int ar = 0; ar < 3; ar++) begin
            d32 = {16'h0000, rnd()};
            event_clear[ar * 32 + d32[4:0]] = 1'b1;
            pulse(2'(ar), d32[4:0]);
            ev_m[ar * 32 + d32[4:0]] = 1'b1;
            chk(event_flags_q, ev_m);
        end
        pulse(2'h3, 5'h1f);
        chk(event_flags_q, ev_m);
        event_any_mask = ev_m & -ev_m;
        @(negedge clk);
        chk(irq_q, 1'b1);
        event_any_mask = '0;
        event_all_mask = '1;
        @(negedge clk);
        chk(irq_q, 1'b0);
        event_all_mask = ev_m;
        @(negedge clk);
        chk(irq_q, 1'b1);
        event_clear = ev_m;
        event_all_mask = '0;
        @(negedge clk);
        event_clear = '0;
        @(negedge clk);
        chk(event_flags_q, 96'h0);
        chk(irq_q, 1'b0);
        $display("TB: event test done");
        end_sim();
    end
endmodule
